// ===== autoload_host.sv
// Controller end: APB registers drive job requests and error reset.
// Assumes an APB master in software; loader transfers come from user ports.
`timescale 1ns/1ps
module autoload_host
  import autoload_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  // Loader user side
  input  wire autoload_pkg::load_op_type ld_op,
  input  wire logic        ld_valid,
  input  wire logic [15:0] ld_data,
  input  wire logic [15:0] ld_tmo,
  input  wire logic        ld_tmo_wr,
  // Link
  autoload_if.host         link
);
  import autoload_pkg::*;

  logic        acc;
  logic        wr;
  logic [1:0]  ev;          // 0 load finished, 1 error raised
  logic [1:0]  sts_q;
  logic [1:0]  mask_q;
  logic        prev_load_q;
  logic        prev_err_q;

  // A write lands only at the edge that completes the access
  assign acc = psel && penable && pready;
  assign wr  = acc && pwrite;
  assign ev  = {link.status_word[load_err_bit] && !prev_err_q,
                !link.status_word[loading_bit] && prev_load_q};

  // ==========================================================================
  // Request words and error reset bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.req_wr   <= 1'b0;
      link.req_lo   <= 16'h0000;
      link.req_hi   <= 16'h0000;
      link.cmd_word <= 16'h0000;
    end else begin
      link.req_wr <= wr && paddr == reg_cmd && pwdata[15:0] >= job_min
                     && pwdata[15:0] <= job_max; // see R1
      if (wr && paddr == reg_cmd) begin
        link.req_lo <= pwdata[15:0];
        link.req_hi <= 16'h0000; // see R2
        // Software sets then clears; the edge acknowledges, see R8
        link.cmd_word[err_reset_bit] <= pwdata[16];
      end
    end
  end

  // Loader transfers pass through, erase first is the loader's duty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.op           <= op_none;
      link.op_valid     <= 1'b0;
      link.op_data_word <= 16'h0000;
      link.tmo_set      <= 16'h0000;
      link.tmo_set_wr   <= 1'b0;
    end else begin
      link.op           <= ld_op; // see R4
      link.op_valid     <= ld_valid;
      link.op_data_word <= ld_data;
      link.tmo_set      <= ld_tmo;
      link.tmo_set_wr   <= ld_tmo_wr;
    end
  end

  // ==========================================================================
  // Interrupt status; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_q       <= 2'b00;
      mask_q      <= 2'b00;
      prev_load_q <= 1'b0;
      prev_err_q  <= 1'b0;
      irq         <= 1'b0;
    end else begin
      prev_load_q <= link.status_word[loading_bit];
      prev_err_q  <= link.status_word[load_err_bit];
      sts_q <= (sts_q & ~((wr && paddr == reg_irq) ? pwdata[1:0] : 2'b00)) | ev; // see R14
      if (wr && paddr == reg_mask) begin
        mask_q <= pwdata[1:0];
      end
      irq <= |(sts_q & mask_q);
    end
  end

  // ==========================================================================
  // APB read path, registered at the end of the setup cycle: no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        case (paddr)
          reg_cmd:    prdata <= {16'h0000, link.job_word};
          reg_status: prdata <= {16'h0000, link.status_word}; // see R13
          reg_irq:    prdata <= {30'h0, sts_q};
          reg_mask:   prdata <= {30'h0, mask_q};
          reg_tmo:    prdata <= {16'h0000, link.timeout_word}; // see R12
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

// ===== autoload_if.sv
// Carrier between the motion unit end and the controller/loader end.
// Assumes both ends share pclk and presetn.
`timescale 1ns/1ps
interface autoload_if (
  input wire logic pclk,
  input wire logic presetn
);
  import autoload_pkg::*;

  // Controller request words
  logic        req_wr;        // One-cycle write of the two-word request
  logic [15:0] req_lo;        // Job number
  logic [15:0] req_hi;        // Must be zero
  logic [15:0] cmd_word;      // First command word (error reset at bit 5)
  // Unit visible state
  logic [15:0] job_word;      // Current job number read back
  logic [15:0] status_word;   // Loading and error flags
  logic [15:0] timeout_word;  // Read-only timeout setting
  // Loader transfer channel
  load_op_type op;            // Transfer kind
  logic        op_valid;      // One-cycle strobe
  logic [15:0] op_data_word;  // Payload
  logic [15:0] tmo_set;       // Timeout setting written by loader tool
  logic        tmo_set_wr;    // Strobe for tmo_set

  modport unit (
    input  req_wr, req_lo, req_hi, cmd_word, op, op_valid, op_data_word, tmo_set, tmo_set_wr,
    output job_word, status_word, timeout_word
  );
  modport host (
    output req_wr, req_lo, req_hi, cmd_word, op, op_valid, op_data_word, tmo_set, tmo_set_wr,
    input  job_word, status_word, timeout_word
  );
endinterface

// ===== autoload_monitor.sv
// Checker for the link between the unit end and the host end.
// Assumes it stands beside the interface instance and sees its signals.
`timescale 1ns/1ps
module autoload_monitor
  import autoload_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Request side of the link
  input wire logic        req_wr,
  input wire logic [15:0] req_lo,
  input wire logic [15:0] req_hi,
  input wire logic [15:0] cmd_word,
  input wire autoload_pkg::load_op_type op,
  input wire logic        op_valid,
  input wire logic        tmo_set_wr,
  // Unit side of the link
  input wire logic [15:0] job_word,
  input wire logic [15:0] status_word,
  input wire logic [15:0] timeout_word
);
  import autoload_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // Helper: quiet cycles while loading, so the timeout can be bounded
  logic [31:0] idle_q;  // Cycles since the last loader transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_q <= '0;
    end else if (!status_word[loading_bit] || op_valid) begin
      idle_q <= '0;
    end else begin
      idle_q <= idle_q + 32'h1;
    end
  end
  // ==========================================================================
  // Steps of a load
  sequence erase_s;
    op_valid && op == op_erase && job_word != job_none;
  endsequence
  sequence done_s;
    op_valid && op == op_done && status_word[loading_bit];
  endsequence
  // ==========================================================================
  // Assertions
  req_range_a: assert property (req_wr |-> req_hi == 16'h0 && req_lo >= job_min && req_lo <= job_max)
    else $error("request with bad job word");
  job_show_a: assert property (req_wr |-> ##2 job_word == $past(req_lo, 2))
    else $error("job number not shown");
  load_rise_a: assert property (erase_s |-> ##[1:2] status_word[loading_bit])
    else $error("loading flag did not rise");
  load_fall_a: assert property (done_s |-> ##4 (!status_word[loading_bit] && job_word == job_none))
    else $error("load end not reported");
  err_rise_a: assert property ($rose(status_word[load_err_bit]) |-> !status_word[loading_bit] && $past(status_word[loading_bit]))
    else $error("error flag outside a load");
  err_clear_a: assert property ($rose(cmd_word[err_reset_bit]) |-> ##[1:2] !status_word[load_err_bit])
    else $error("error flag not cleared");
  tmo_bound_a: assert property (status_word[loading_bit] |-> idle_q <= timeout_word * ms_cycles + 4)
    else $error("load timeout missed");
  // The word loads its default just after release, so wait two settled cycles
  tmo_ro_a: assert property (!$stable(timeout_word) && $past(presetn, 2) |-> $past(tmo_set_wr) || $past(tmo_set_wr, 2))
    else $error("timeout word changed unasked");
endmodule

// ===== autoload_pkg.sv
// Shared constants and types for the job autoload controller and its loader end.
// Assumes a single 40 MHz clock and word-wide register accesses over the link.
package autoload_pkg;

  // ==========================================================================
  // Device word addresses (word-index space of the unit)
  localparam logic [15:0] job_load_request_addr         = 16'h17d8; // Low word, high at +1
  localparam logic [15:0] autoload_timeout_setting_addr = 16'h0fa9; // Read-only word

  // ==========================================================================
  // Job number range
  localparam logic [15:0] job_min  = 16'h0001;
  localparam logic [15:0] job_max  = 16'h2710;
  localparam logic [15:0] job_none = 16'h0000;

  // ==========================================================================
  // Status and command bit positions
  localparam int loading_bit    = 4;
  localparam int load_err_bit   = 5;
  localparam int err_reset_bit  = 5;

  // ==========================================================================
  // Storage capacity
  localparam int max_programs = 100;
  localparam int max_blocks   = 2000;
  localparam int prog_aw      = 7;   // Index width for program slots
  localparam int blk_aw       = 11;  // Count width for blocks

  // ==========================================================================
  // Timeout: setting is in milliseconds
  localparam int clk_hz          = 40000000;
  localparam int ms_cycles       = clk_hz / 1000;
  localparam logic [15:0] timeout_reset_ms = 16'h2710; // 10 s default

  // ==========================================================================
  // APB register offsets of the controller-side block
  localparam logic [11:0] reg_cmd    = 12'h000; // Write: job, bit 16 = error reset
  localparam logic [11:0] reg_status = 12'h004; // Read: flags
  localparam logic [11:0] reg_irq    = 12'h008; // Sticky events, write 1 to clear
  localparam logic [11:0] reg_mask   = 12'h00c; // Interrupt mask
  localparam logic [11:0] reg_tmo    = 12'h010; // Read-only timeout setting

  // Loader transfer kinds
  typedef enum logic [1:0] {
    op_none  = 2'b00,
    op_erase = 2'b01,
    op_data  = 2'b10,
    op_done  = 2'b11
  } load_op_type;

endpackage

// ===== autoload_unit.sv
// Motion unit end: job request word, load flags, timeout and program store.
// Assumes the far end erases before loading and keeps job numbers in range.
// How it works
// R1: Requester writes job 1 to 10000 only
// R2: Request is two words, upper zero
// R3: Current job number always visible to loader
// R4: Loader erases all programs before downloading
// R5: Request word reads zero after power-on or completion
// R6: Loading flag spans download, status bit 4
// R7: Error during loading sets error flag bit 5
// R8: Error reset rising edge clears error flag
// R9: Persisting fault sets error again next attempt
// R10: Loader silence past timeout raises error
// R11: Timeout discards data received for the job
// R12: Timeout setting is read-only to controller
// R13: Controller times request-to-loading-start itself
// R14: Broken download needs a repeated request
// R15: Requests accepted in automatic and manual modes
// R16: Store holds 100 programs, 2000 blocks
// R17: Timeout clears loading flag with error
`timescale 1ns/1ps
module autoload_unit
  import autoload_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Operating mode (0 manual, 1 automatic), either accepted
  input  wire logic auto_mode,
  // Link to the controller and loader
  autoload_if.unit  link,
  // Store occupancy
  output logic [6:0]  prog_count,
  output logic [10:0] blk_count
);
  import autoload_pkg::*;

  // ==========================================================================
  // State
  logic [15:0] job_q;        // Requested or executing job
  logic        loading_q;    // Download in progress
  logic        err_q;        // Autoload error
  logic        pending_q;    // Request accepted, download not yet begun
  logic        rst_bit_q;    // Previous error reset bit level
  logic [15:0] tmo_ms_q;     // Timeout setting in ms
  logic [31:0] idle_q;       // Cycles since last loader activity
  logic [6:0]  prog_q;       // Programs stored
  logic [10:0] blk_q;        // Blocks stored
  logic        err_rise;
  logic        tmo_fire;
  logic        bad_op;
  logic        req_ok;

  // Mode does not gate requests
  assign req_ok   = link.req_wr && (link.req_hi == 16'h0000)
                    && (link.req_lo >= job_min) && (link.req_lo <= job_max); // see R15
  assign err_rise = link.cmd_word[err_reset_bit] && !rst_bit_q;              // see R8
  assign tmo_fire = loading_q && (idle_q >= 32'(tmo_ms_q) * 32'(ms_cycles));  // see R10
  // A new program past 100 or a block past 2000 is a load fault
  assign bad_op   = loading_q && link.op_valid && link.op == op_data && (blk_q >= 11'(max_blocks)
                    || (link.op_data_word[15] && prog_q >= 7'(max_programs))); // see R16

  // ==========================================================================
  // Job number word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      job_q <= job_none; // see R5
    end else if (req_ok) begin
      job_q <= link.req_lo; // see R3
    end else if (loading_q && link.op_valid && link.op == op_done) begin
      job_q <= job_none; // see R5
    end
  end

  // ==========================================================================
  // Loading flag and pending request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loading_q <= 1'b0;
      pending_q <= 1'b0;
    end else if (tmo_fire || bad_op) begin
      loading_q <= 1'b0; // see R17
      pending_q <= 1'b0;
    end else if (req_ok) begin
      pending_q <= 1'b1; // No timing here; controller supervises, see R13
    end else if (pending_q && link.op_valid && link.op == op_erase) begin
      loading_q <= 1'b1; // see R6
      pending_q <= 1'b0;
    end else if (loading_q && link.op_valid && link.op == op_done) begin
      loading_q <= 1'b0; // see R6
    end
  end

  // ==========================================================================
  // Error flag: set wins over reset edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else if (tmo_fire || bad_op) begin
      err_q <= 1'b1; // see R7, R9, R10
    end else if (err_rise) begin
      err_q <= 1'b0; // see R8
    end
  end

  // Reset bit history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_bit_q <= 1'b0;
    end else begin
      rst_bit_q <= link.cmd_word[err_reset_bit];
    end
  end

  // ==========================================================================
  // Timeout setting, written only by the loader tool
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_ms_q <= timeout_reset_ms;
    end else if (link.tmo_set_wr) begin
      tmo_ms_q <= link.tmo_set; // see R12
    end
  end

  // Silence counter, restarted by any loader activity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_q <= 32'h0000_0000;
    end else if (!loading_q || link.op_valid) begin
      idle_q <= 32'h0000_0000;
    end else if (idle_q != 32'hffff_ffff) begin
      idle_q <= idle_q + 32'h0000_0001;
    end
  end

  // ==========================================================================
  // Program store occupancy; erase empties all tasks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_q <= 7'h00;
      blk_q  <= 11'h000;
    end else if (tmo_fire) begin
      prog_q <= 7'h00; // Partial job dropped, see R11
      blk_q  <= 11'h000;
    end else if (pending_q && link.op_valid && link.op == op_erase) begin
      prog_q <= 7'h00; // see R4
      blk_q  <= 11'h000;
    end else if (loading_q && link.op_valid && link.op == op_data && !bad_op) begin
      // Payload bit 15 marks the first block of a new program
      if (link.op_data_word[15]) begin
        prog_q <= prog_q + 7'h01;
      end
      blk_q <= blk_q + 11'h001;
    end
  end

  // ==========================================================================
  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.job_word     <= 16'h0000;
      link.status_word  <= 16'h0000;
      link.timeout_word <= 16'h0000;
      prog_count        <= 7'h00;
      blk_count         <= 11'h000;
    end else begin
      link.job_word     <= job_q;
      link.status_word  <= 16'(loading_q) << loading_bit | 16'(err_q) << load_err_bit;
      link.timeout_word <= tmo_ms_q;
      prog_count        <= prog_q;
      blk_count         <= blk_q;
    end
  end

  // Mode input only documents that both modes are served
  logic unused_mode;
  assign unused_mode = auto_mode;
endmodule

// ===== test_job_autoload_control.sv
// Testbench: host end and unit end joined by the link, driven over APB.
// Assumes the loader user ports stand in for the loader tool.
`timescale 1ns/1ps
module test_job_autoload_control;
  import autoload_pkg::*;
  // ==========================================================================
  // Stimulus and observed signals
  logic        pclk = 1'b0;       // 40 MHz
  logic        presetn = 1'b0;    // Held low for 12 cycles
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        auto_mode = 1'b0;  // Manual first, then automatic
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, r;         // Bus read data and last taken value
  logic        pready, pslverr, irq, e;
  load_op_type ld_op = op_none;
  logic        ld_valid = 1'b0;
  logic        ld_tmo_wr = 1'b0;
  logic [15:0] ld_data = '0;
  logic [15:0] ld_tmo = '0;
  logic [15:0] j;                 // Job under test
  logic [6:0]  pc;
  logic [10:0] bc;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          i;
  always #12.5 pclk = ~pclk;
  // ==========================================================================
  // Both ends face each other across the link
  autoload_if autoload_if_inst (.pclk(pclk), .presetn(presetn));
  autoload_unit autoload_unit_inst (.pclk(pclk), .presetn(presetn), .auto_mode(auto_mode),
    .link(autoload_if_inst.unit), .prog_count(pc), .blk_count(bc));
  autoload_host autoload_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .ld_op(ld_op), .ld_valid(ld_valid),
    .ld_data(ld_data), .ld_tmo(ld_tmo), .ld_tmo_wr(ld_tmo_wr), .link(autoload_if_inst.host));
  autoload_monitor autoload_monitor_inst (.pclk(pclk), .presetn(presetn),
    .req_wr(autoload_if_inst.req_wr), .req_lo(autoload_if_inst.req_lo),
    .req_hi(autoload_if_inst.req_hi), .cmd_word(autoload_if_inst.cmd_word),
    .op(autoload_if_inst.op), .op_valid(autoload_if_inst.op_valid),
    .tmo_set_wr(autoload_if_inst.tmo_set_wr), .job_word(autoload_if_inst.job_word),
    .status_word(autoload_if_inst.status_word),
    .timeout_word(autoload_if_inst.timeout_word));
  // ==========================================================================
  // Closing report, the only place the run ends
  task end_sim();
    $display("mismatches %0d of %0d checks", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request is held until pready is seen
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_errors++;
      end_sim();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  // Job request; error reset bit kept low
  task req(input logic [15:0] n);
    apb(1'b1, reg_cmd, {16'h0, n});
    repeat (4) @(posedge pclk);
  endtask
  // One loader transfer, then time for the flags to settle
  task ld(input load_op_type o, input logic [15:0] d);
    @(posedge pclk);
    ld_op <= o;
    ld_data <= d;
    ld_valid <= 1'b1;
    @(posedge pclk);
    ld_valid <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    // Reset values, read-only timeout word, unmapped offset
    rd(reg_status, 32'h0);
    chk(autoload_if_inst.job_word, 16'h0);
    rd(reg_tmo, {16'h0, timeout_reset_ms});
    apb(1'b1, reg_tmo, 32'h1);
    rd(reg_tmo, {16'h0, timeout_reset_ms});
    rd(12'h020, 32'h0);
    chk(e, 1'b1);
    $display("test reset done");
    // Jobs outside the range are ignored
    req(16'h0000);
    chk(autoload_if_inst.job_word, 16'h0);
    req(16'h2711);
    chk(autoload_if_inst.job_word, 16'h0);
    $display("test range done");
    // Whole load at both ends of the job range, manual then automatic
    apb(1'b1, reg_mask, 32'h3);
    for (int m = 0; m < 2; m++) begin
      auto_mode <= m[0];
      j = m[0] ? job_min : job_max;
      req(j);
      chk(autoload_if_inst.job_word, j);
      ld(op_erase, 16'h0);
      ld(op_data, 16'h8000);
      ld(op_data, 16'h0001);
      rd(reg_status, 32'h10);
      ld(op_done, 16'h0);
      rd(reg_status, 32'h0);
      chk(autoload_if_inst.job_word, 16'h0);
      chk(pc, 7'h1);
      chk(bc, 11'h2);
      chk(irq, 1'b1);
      apb(1'b1, reg_irq, 32'h1);
      rd(reg_irq, 32'h0);
      chk(irq, 1'b0);
    end
    $display("test load done");
    // Loader falls silent: 1 ms timeout, masked then unmasked interrupt
    @(posedge pclk);
    ld_tmo <= 16'h1;
    ld_tmo_wr <= 1'b1;
    @(posedge pclk);
    ld_tmo_wr <= 1'b0;
    repeat (3) @(posedge pclk);
    rd(reg_tmo, 32'h1);
    apb(1'b1, reg_mask, 32'h0);
    req(16'h0005);
    ld(op_erase, 16'h0);
    ld(op_data, 16'h8000);
    for (i = 0; i < 45000 && autoload_if_inst.status_word[load_err_bit] !== 1'b1; i++) begin
      @(posedge pclk);
    end
    chk(i >= 39990 && i < 45000, 1'b1);
    rd(reg_status, 32'h20);
    chk(pc, 7'h0);
    chk(bc, 11'h0);
    rd(reg_cmd, 32'h5);
    chk(irq, 1'b0);
    apb(1'b1, reg_mask, 32'h2);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    apb(1'b1, reg_cmd, 32'h10000);
    // The cleared flag reaches the status word two edges after the write
    repeat (2) @(posedge pclk);
    rd(reg_status, 32'h0);
    apb(1'b1, reg_irq, 32'h3);
    $display("test timeout done");
    // Store overflow twice: the error returns after each reset
    for (int k = 0; k < 2; k++) begin
      req(16'h0007);
      ld(op_erase, 16'h0);
      for (int p = 0; p < max_programs; p++) begin
        ld(op_data, 16'h8000);
      end
      rd(reg_status, 32'h10);
      ld(op_data, 16'h8000);
      rd(reg_status, 32'h20);
      chk(pc, 7'h64);
      chk(bc, 11'h064);
      apb(1'b1, reg_cmd, 32'h10000);
    end
    $display("test overflow done");
    end_sim();
  end
endmodule
